/* design/txs_defs.svh */
// Register indexes, field positions and reset values of the stats block
`ifndef TXS_DEFS_SVH
`define TXS_DEFS_SVH

// Register indexes; byte address is four times the index
`define TXS_IDX_REVISION   12'h840
`define TXS_IDX_SCRATCH    12'h841
`define TXS_IDX_IDENT_0    12'h842
`define TXS_IDX_IDENT_1    12'h843
`define TXS_IDX_IDENT_2    12'h844
`define TXS_IDX_CONTROL    12'h845
`define TXS_IDX_STATE      12'h846
`define TXS_IDX_IRQ_STAT   12'h847
`define TXS_IDX_IRQ_MASK   12'h848
`define TXS_IDX_BYTES_LO   12'h860
`define TXS_IDX_BYTES_HI   12'h861

// Control register fields
`define TXS_CTL_CLEAR_ALL  0
`define TXS_CTL_PAR_CLEAR  1
`define TXS_CTL_SNAPSHOT   2

// State register fields
`define TXS_ST_PAR_ERR     0
`define TXS_ST_PAUSED      1

// Interrupt status and mask fields
`define TXS_IRQ_PAR_ERR    0
`define TXS_IRQ_WRAP       1
`define TXS_IRQ_CLEARED    2
`define TXS_IRQ_W          3

// Reset values
`define TXS_SCRATCH_RST    32'h0000_0008
`define TXS_MASK_RST       3'h0

`endif

/* design/txs_pkg.sv */
// Types shared by the transmit statistics control block
package txs_pkg;

  // Whole state of the block, registered as one word
  typedef struct packed {
    logic [63:0] count;
    logic [1:0]  par;
    logic [63:0] shadow;
    logic        snap;
    logic        par_err;
    logic [31:0] scratch;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    logic        irq;
    logic        ack;
    logic [31:0] dat;
  } txs_state_t;

endpackage : txs_pkg

/* design/txs_tx_stats_ctrl.sv */
// Transmit statistics control, status, identity and good-byte counter
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps
`include "txs_defs.svh"

module txs_tx_stats_ctrl #(
  parameter logic [31:0] REVISION = 32'h0000_0001,
  parameter logic [95:0] IDENT    = 96'h7478_5374_6174_7342_6C6F_636B
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [13:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [15:0] good_byte_increment_i,
  input  wire logic        good_byte_increment_strobe_i,
  output logic             irq_o
);
  // REVISION and IDENT defaults are arbitrary values

  txs_pkg::txs_state_t r;
  txs_pkg::txs_state_t n;

  logic        access;
  logic        wr_take;
  logic        rd_take;
  logic        rd_start;
  logic [11:0] idx;
  logic        ctl_wr;
  logic        clr_all;
  logic        par_clr;
  logic [64:0] sum;
  logic        wrap;
  logic [1:0]  par_bad;
  logic        par_err_ev;
  logic [31:0] rd_val;

  // Stored parity is checked against each counter half every cycle
  genvar h;
  generate
    for (h = 0; h < 2; h = h + 1) begin : g_par
      assign par_bad[h] = (^r.count[h*32 +: 32]) ^ r.par[h];
    end
  endgenerate

  always_comb begin
    n = r;
    access   = wb_cyc_i & wb_stb_i;
    idx      = wb_adr_i[13:2];
    // Writes and read side effects act on the edge where ack is seen
    wr_take  = access & wb_we_i & r.ack;
    rd_take  = access & ~wb_we_i & r.ack;
    rd_start = access & ~wb_we_i & ~r.ack;
    ctl_wr   = wr_take & wb_sel_i[0] & (idx == `TXS_IDX_CONTROL);
    clr_all  = ctl_wr & wb_dat_i[`TXS_CTL_CLEAR_ALL];
    par_clr  = ctl_wr & wb_dat_i[`TXS_CTL_PAR_CLEAR];
    par_err_ev = |par_bad;

    // Good-byte counter; it rolls over and flags the wrap
    sum  = {1'b0, r.count} + {49'h0, good_byte_increment_i};
    wrap = 1'b0;
    if (clr_all) begin
      // An increment in the clearing cycle is kept, not lost
      if (good_byte_increment_strobe_i) begin
        n.count = {48'h0, good_byte_increment_i};
      end else begin
        n.count = 64'h0;
      end
    end else if (good_byte_increment_strobe_i) begin
      n.count = sum[63:0];
      wrap    = sum[64];
    end
    n.par = {^n.count[63:32], ^n.count[31:0]};

    // Snapshot bit
    if (ctl_wr) begin
      n.snap = wb_dat_i[`TXS_CTL_SNAPSHOT];
    end
    // Readable copy follows the live count unless frozen; clear-all reloads it even when frozen
    if (clr_all) begin
      n.shadow = n.count;
    end else if (!n.snap) begin
      n.shadow = n.count;
    end

    // Parity flag: a new error wins over a clear in the same cycle
    if (par_err_ev) begin
      n.par_err = 1'b1;
    end else if (par_clr) begin
      n.par_err = 1'b0;
    end

    // Scratch, byte lanes honoured
    if (wr_take && idx == `TXS_IDX_SCRATCH) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          n.scratch[b*8 +: 8] = wb_dat_i[b*8 +: 8];
        end
      end
    end

    if (wr_take && wb_sel_i[0] && idx == `TXS_IDX_IRQ_MASK) begin
      n.irq_mask = wb_dat_i[`TXS_IRQ_W-1:0];
    end

    // Interrupt status: read clears, new events win
    if (rd_take && idx == `TXS_IDX_IRQ_STAT) begin
      n.irq_stat = 3'h0;
    end
    if (par_err_ev) begin
      n.irq_stat[`TXS_IRQ_PAR_ERR] = 1'b1;
    end
    if (wrap) begin
      n.irq_stat[`TXS_IRQ_WRAP] = 1'b1;
    end
    if (clr_all) begin
      n.irq_stat[`TXS_IRQ_CLEARED] = 1'b1;
    end
    n.irq = |(n.irq_stat & n.irq_mask);

    // Read mux; unmapped words read as zero
    rd_val = 32'h0;
    if (idx == `TXS_IDX_REVISION) begin
      rd_val = REVISION;
    end else if (idx == `TXS_IDX_SCRATCH) begin
      rd_val = r.scratch;
    end else if (idx == `TXS_IDX_IDENT_0) begin
      rd_val = IDENT[95:64];
    end else if (idx == `TXS_IDX_IDENT_1) begin
      rd_val = IDENT[63:32];
    end else if (idx == `TXS_IDX_IDENT_2) begin
      rd_val = IDENT[31:0];
    end else if (idx == `TXS_IDX_CONTROL) begin
      // Self-clearing bits always read 0
      rd_val = {29'h0, r.snap, 2'h0};
    end else if (idx == `TXS_IDX_STATE) begin
      rd_val = {30'h0, r.snap, r.par_err};
    end else if (idx == `TXS_IDX_IRQ_STAT) begin
      rd_val = {29'h0, r.irq_stat};
    end else if (idx == `TXS_IDX_IRQ_MASK) begin
      rd_val = {29'h0, r.irq_mask};
    end else if (idx == `TXS_IDX_BYTES_LO) begin
      rd_val = r.shadow[31:0];
    end else if (idx == `TXS_IDX_BYTES_HI) begin
      rd_val = r.shadow[63:32];
    end

    // One-cycle ack, one cycle after the request
    n.ack = access & ~r.ack;
    n.dat = rd_start ? rd_val : 32'h0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r          <= '0;
      r.scratch  <= `TXS_SCRATCH_RST;
      r.irq_mask <= `TXS_MASK_RST;
    end else begin
      r <= n;
    end
  end

  assign wb_dat_o = r.dat;
  assign wb_ack_o = r.ack;
  assign irq_o    = r.irq;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_scratch_reset: assert property (
    $past(rst_i) |-> r.scratch == `TXS_SCRATCH_RST)
    else $error("scratch not at reset value");

  a_snap_freeze: assert property (
    r.snap && $past(r.snap) && !$past(clr_all)
      |-> r.shadow == $past(r.shadow))
    else $error("snapshot value moved while frozen");

  a_snap_counts: assert property (
    r.snap && good_byte_increment_strobe_i && !clr_all
      |=> r.count == $past(r.count) + 64'($past(good_byte_increment_i)))
    else $error("live count stopped during snapshot");

  a_octet_add: assert property (
    good_byte_increment_strobe_i && !clr_all
      |=> r.count == $past(r.count) + 64'($past(good_byte_increment_i)))
    else $error("increment not added to live count");

  a_par_clear: assert property (
    par_clr && !par_err_ev |=> !r.par_err)
    else $error("parity flag not cleared");

  a_clear_all: assert property (
    clr_all && !good_byte_increment_strobe_i
      |=> r.count == 64'h0 && r.shadow == 64'h0)
    else $error("counters not cleared");

  a_paused_bit: assert property (
    rd_start && idx == `TXS_IDX_STATE
      |=> wb_ack_o && wb_dat_o[`TXS_ST_PAUSED] == $past(r.snap))
    else $error("paused bit does not match snapshot bit");

  a_par_sticky: assert property (
    par_err_ev |=> r.par_err [*2] or (r.par_err ##1 $past(par_clr)))
    else $error("parity flag not set");

  a_rsvd_zero: assert property (
    rd_start && idx == `TXS_IDX_CONTROL
      |=> wb_dat_o[31:3] == 29'h0 && wb_dat_o[`TXS_CTL_PAR_CLEAR] == 1'b0)
    else $error("reserved control bits not zero");

  a_rsvd_state: assert property (
    rd_start && idx == `TXS_IDX_STATE |=> wb_dat_o[31:2] == 30'h0)
    else $error("reserved state bits not zero");

  a_ctl_selfclr: assert property (
    rd_start && idx == `TXS_IDX_CONTROL
      |=> wb_dat_o[1:0] == 2'h0
          && wb_dat_o[`TXS_CTL_SNAPSHOT] == $past(r.snap))
    else $error("control bits read back wrong");

  a_ident_order: assert property (
    rd_start && idx == `TXS_IDX_IDENT_0 |=> wb_dat_o == IDENT[95:64])
    else $error("identity word out of order");

  a_count_split: assert property (
    rd_start && idx == `TXS_IDX_BYTES_HI
      |=> wb_dat_o == $past(r.shadow[63:32]))
    else $error("high count word wrong");

  a_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  // Handshake: one answer per request, data only beside ack
  a_ack_answer: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");

  a_ack_idle: assert property (
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without a request");

  a_dat_idle: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside the ack cycle");

  a_wr_quiet: assert property (
    wr_take |-> wb_ack_o && wb_dat_o == 32'h0)
    else $error("write answered with data");

  // Register checks
  a_rev_read: assert property (
    rd_start && idx == `TXS_IDX_REVISION |=> wb_dat_o == REVISION)
    else $error("revision word wrong");

  a_ident_mid: assert property (
    rd_start && idx == `TXS_IDX_IDENT_1 |=> wb_dat_o == IDENT[63:32])
    else $error("middle identity word wrong");

  a_ident_last: assert property (
    rd_start && idx == `TXS_IDX_IDENT_2 |=> wb_dat_o == IDENT[31:0])
    else $error("last identity word wrong");

  a_scratch_read: assert property (
    rd_start && idx == `TXS_IDX_SCRATCH
      |=> wb_dat_o == $past(r.scratch))
    else $error("scratch read back wrong");

  a_scratch_write: assert property (
    wr_take && idx == `TXS_IDX_SCRATCH && wb_sel_i == 4'hF
      |=> r.scratch == $past(wb_dat_i))
    else $error("scratch write lost");

  a_scratch_hold: assert property (
    !(wr_take && idx == `TXS_IDX_SCRATCH)
      |=> r.scratch == $past(r.scratch))
    else $error("scratch changed without a write");

  a_snap_write: assert property (
    ctl_wr |=> r.snap == $past(wb_dat_i[`TXS_CTL_SNAPSHOT]))
    else $error("snapshot bit not written");

  a_snap_hold: assert property (
    !ctl_wr |=> r.snap == $past(r.snap))
    else $error("snapshot bit changed without a write");

  a_snap_release: assert property (
    !r.snap |-> r.shadow == r.count)
    else $error("readable count not following live count");

  a_clear_keep: assert property (
    clr_all && good_byte_increment_strobe_i
      |=> r.count == {48'h0, $past(good_byte_increment_i)})
    else $error("increment lost in clearing cycle");

  a_clear_shadow: assert property (
    clr_all |=> r.shadow == r.count)
    else $error("readable count not cleared");

  a_count_idle: assert property (
    !good_byte_increment_strobe_i && !clr_all
      |=> r.count == $past(r.count))
    else $error("count moved without a strobe");

  a_count_low: assert property (
    rd_start && idx == `TXS_IDX_BYTES_LO
      |=> wb_dat_o == $past(r.shadow[31:0]))
    else $error("low count word wrong");

  a_state_parity: assert property (
    rd_start && idx == `TXS_IDX_STATE
      |=> wb_dat_o[`TXS_ST_PAR_ERR] == $past(r.par_err))
    else $error("parity bit does not match flag");

  a_par_hold: assert property (
    r.par_err && !par_clr |=> r.par_err)
    else $error("parity flag dropped without a clear");

  a_par_only: assert property (
    !r.par_err && !par_err_ev |=> !r.par_err)
    else $error("parity flag set without an error");

  // Wrap and parity events need a fault or 2^64 bytes to show up
  a_irq_sticky: assert property (
    !(rd_take && idx == `TXS_IDX_IRQ_STAT)
      |=> (r.irq_stat & $past(r.irq_stat)) == $past(r.irq_stat))
    else $error("event bit lost without a read");

  a_irq_rdclr: assert property (
    rd_take && idx == `TXS_IDX_IRQ_STAT && !par_err_ev && !wrap
      |=> r.irq_stat == 3'h0)
    else $error("event bits not cleared by read");

  a_clear_event: assert property (
    clr_all |=> r.irq_stat[`TXS_IRQ_CLEARED])
    else $error("clear-all event not recorded");

  a_stat_read: assert property (
    rd_start && idx == `TXS_IDX_IRQ_STAT
      |=> wb_dat_o == {29'h0, $past(r.irq_stat)})
    else $error("event word read back wrong");

  a_mask_read: assert property (
    rd_start && idx == `TXS_IDX_IRQ_MASK
      |=> wb_dat_o == {29'h0, $past(r.irq_mask)})
    else $error("mask word read back wrong");

  a_mask_write: assert property (
    wr_take && wb_sel_i[0] && idx == `TXS_IDX_IRQ_MASK
      |=> r.irq_mask == $past(wb_dat_i[2:0]))
    else $error("mask write lost");

  a_mask_hold: assert property (
    !(wr_take && idx == `TXS_IDX_IRQ_MASK)
      |=> r.irq_mask == $past(r.irq_mask))
    else $error("mask changed without a write");

endmodule : txs_tx_stats_ctrl

/* verif/tx_statistics_control_test.sv */
// Self-checking bench for the transmit statistics control block
`timescale 1ns/1ps
`include "txs_defs.svh"
module tx_statistics_control_test;
  // Arbitrary neutral identity values
  localparam logic [31:0] REV = 32'h0000_00A5;
  localparam logic [95:0] IDT = "abcdEFGHijkl";
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [13:0] wb_adr_i = 14'h0000;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [15:0] inc = 16'h0000;
  logic        inc_stb = 1'b0;
  logic        irq_o;
  logic [31:0] rd;
  int          num_errors = 0;
  int          n_compared = 0;
  int          cycles = 0;

  txs_tx_stats_ctrl #(.REVISION(REV), .IDENT(IDT)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .good_byte_increment_i(inc), .good_byte_increment_strobe_i(inc_stb),
    .irq_o(irq_o));

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  task automatic finish_test;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // Whole run needs well under this many cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles > 4000) begin
      num_errors = num_errors + 1;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One classic cycle; data is taken at the edge where ack is seen high
  task automatic wb(input logic we, input logic [11:0] idx,
                    input logic [31:0] wd, output logic [31:0] dat);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'h0};
    wb_dat_i <= wd;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    dat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic pump(input logic [15:0] v, input int n);
    inc     <= v;
    inc_stb <= 1'b1;
    repeat (n) @(posedge clk_i);
    inc_stb <= 1'b0;
    @(posedge clk_i);
  endtask : pump

  task automatic t_ident;
    wb(1'b0, `TXS_IDX_SCRATCH, 0, rd); check(rd, 32'h0000_0008);
    wb(1'b1, `TXS_IDX_SCRATCH, 32'hA5C3_0F96, rd);
    wb(1'b0, `TXS_IDX_SCRATCH, 0, rd); check(rd, 32'hA5C3_0F96);
    wb_sel_i <= 4'h2;
    wb(1'b1, `TXS_IDX_SCRATCH, 32'h1234_5678, rd);
    wb_sel_i <= 4'hF;
    wb(1'b0, `TXS_IDX_SCRATCH, 0, rd); check(rd, 32'hA5C3_5696);
    wb(1'b1, `TXS_IDX_REVISION, 32'hFFFF_FFFF, rd);
    wb(1'b0, `TXS_IDX_REVISION, 0, rd); check(rd, REV);
    wb(1'b0, `TXS_IDX_IDENT_0, 0, rd); check(rd, IDT[95:64]);
    wb(1'b0, `TXS_IDX_IDENT_1, 0, rd); check(rd, IDT[63:32]);
    wb(1'b0, `TXS_IDX_IDENT_2, 0, rd); check(rd, IDT[31:0]);
    wb(1'b0, 12'h838, 0, rd); check(rd, 32'h0000_0000);
  endtask : t_ident

  task automatic t_count;
    pump(16'hFFFF, 4);
    wb(1'b0, `TXS_IDX_BYTES_LO, 0, rd); check(rd, 32'h0003_FFFC);
    wb(1'b0, `TXS_IDX_BYTES_HI, 0, rd); check(rd, 32'h0000_0000);
  endtask : t_count

  // Frozen view must hold while the live count keeps moving
  task automatic t_snap;
    wb(1'b1, `TXS_IDX_CONTROL, 32'hFFFF_FFFC, rd);
    wb(1'b0, `TXS_IDX_CONTROL, 0, rd); check(rd, 32'h0000_0004);
    wb(1'b0, `TXS_IDX_STATE, 0, rd); check(rd, 32'h0000_0002);
    pump(16'h0100, 3);
    wb(1'b0, `TXS_IDX_BYTES_LO, 0, rd); check(rd, 32'h0003_FFFC);
    wb(1'b0, `TXS_IDX_BYTES_HI, 0, rd); check(rd, 32'h0000_0000);
    wb(1'b1, `TXS_IDX_CONTROL, 32'h0000_0000, rd);
    wb(1'b0, `TXS_IDX_STATE, 0, rd); check(rd, 32'h0000_0000);
    wb(1'b0, `TXS_IDX_BYTES_LO, 0, rd); check(rd, 32'h0004_02FC);
  endtask : t_snap

  task automatic t_clear(input logic [2:0] mask, input logic irq_exp);
    wb(1'b1, `TXS_IDX_IRQ_MASK, {29'h0, mask}, rd);
    pump(16'h0010, 2);
    wb(1'b1, `TXS_IDX_CONTROL, 32'h0000_0003, rd);
    repeat (2) @(posedge clk_i);
    check({31'h0, irq_o}, {31'h0, irq_exp});
    wb(1'b0, `TXS_IDX_CONTROL, 0, rd); check(rd, 32'h0000_0000);
    wb(1'b0, `TXS_IDX_STATE, 0, rd); check(rd, 32'h0000_0000);
    wb(1'b0, `TXS_IDX_BYTES_LO, 0, rd); check(rd, 32'h0000_0000);
    wb(1'b0, `TXS_IDX_BYTES_HI, 0, rd); check(rd, 32'h0000_0000);
    wb(1'b0, `TXS_IDX_IRQ_STAT, 0, rd); check(rd, 32'h0000_0004);
    repeat (2) @(posedge clk_i);
    check({31'h0, irq_o}, 32'h0000_0000);
    wb(1'b0, `TXS_IDX_IRQ_STAT, 0, rd); check(rd, 32'h0000_0000);
  endtask : t_clear

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_ident();
    t_count();
    t_snap();
    t_clear(3'h0, 1'b0);
    t_clear(3'h4, 1'b1);
    finish_test();
  end
endmodule : tx_statistics_control_test
